// file: common/tbrc_pkg.sv
// Purpose: constants for the timer b / timer c reload and control block
// Assumes: APB, 32-bit data, byte-wide registers in the low bits
// Notes: printed offsets are indices; byte address is four times the index
package tbrc_pkg;
   localparam logic [7:0] TBRC_IDX_B_RELOAD_HIGH = 8'h1A;
   localparam logic [7:0] TBRC_IDX_B_RELOAD_LOW = 8'h1B;
   localparam logic [7:0] TBRC_IDX_B_COUNT_HIGH = 8'h1C;
   localparam logic [7:0] TBRC_IDX_B_COUNT_LOW = 8'h1D;
   localparam logic [7:0] TBRC_IDX_C_CONTROL = 8'h1E;
   localparam logic [7:0] TBRC_IDX_C_RELOAD_HIGH = 8'h1F;
   localparam logic [7:0] TBRC_IDX_C_RELOAD_LOW = 8'h20;
   localparam logic [7:0] TBRC_IDX_B_CONTROL = 8'h30;
   localparam logic [7:0] TBRC_IDX_STATUS = 8'h31;
   localparam logic [7:0] TBRC_IDX_MASK = 8'h32;
   localparam logic [7:0] TBRC_IDX_C_COUNT_HIGH = 8'h33;
   localparam logic [7:0] TBRC_IDX_C_COUNT_LOW = 8'h34;
   localparam int TBRC_STOP_RX_BIT = 7;
   localparam int TBRC_START_HI = 5;
   localparam int TBRC_START_LO = 4;
   localparam int TBRC_AUTO_BIT = 3;
   localparam int TBRC_CLK_HI = 1;
   localparam int TBRC_CLK_LO = 0;
   localparam logic [7:0] TBRC_CONTROL_MASK = 8'hBB;
   localparam logic [1:0] TBRC_START_NONE = 2'h0;
   localparam logic [1:0] TBRC_START_EOT = 2'h1;
   localparam logic [1:0] TBRC_START_TRIM = 2'h2;
   localparam logic [1:0] TBRC_START_TRIM_UF = 2'h3;
   localparam logic [1:0] TBRC_CLK_FAST = 2'h0;
   localparam logic [1:0] TBRC_CLK_SLOW = 2'h1;
   localparam logic [1:0] TBRC_CLK_UF_A = 2'h2;
   localparam logic [1:0] TBRC_CLK_UF_OTHER = 2'h3;
   localparam logic [7:0] TBRC_RESET_BYTE = 8'h00;
   localparam logic [15:0] TBRC_RESET_COUNT = 16'h0000;
   localparam logic [2:0] TBRC_RX_STOP_BITS = 3'h4;
   localparam int TBRC_IRQ_B = 0;
   localparam int TBRC_IRQ_C = 1;
endpackage

// file: logic/tbrc_top.sv
// Purpose: second and third countdown timers with reload, control and irq
// Assumes: tick, event and receive inputs are pulses from core_clk logic
// Notes: pins trim_edge is asynchronous and is synchronised first
// How it works
// - on start, timer b loads reload high and low bytes as one value
// - reload writes never touch a running count, only the next start or auto-restart reload
// - on start, timer c loads its reload high and low bytes together
// - timer b count readable as high byte then low byte, read only
// - stop-on-receive halts timer c after the first four received bits
// - stop-on-receive ignored when start mode selects trimming
// - start mode: none, end of transmission, trimming, trimming with underflow
// - timer c auto-restart reloads after zero, else stops at zero
// - timer c underflow sets its sticky interrupt flag in every start mode except trimming without underflow
// - clock select: fast, slow, timer a underflow, the other timer's underflow
// - control byte: stop bit 7, start 5:4, restart 3, clock 1:0
// - reload bytes at consecutive addresses 1Ah/1Bh and 1Fh/20h
// - timer b auto-restart reloads after zero, flags underflow
module tbrc_top
   import tbrc_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic tick_fast,
   input wire logic tick_slow,
   input wire logic timer_a_underflow,
   input wire logic end_of_tx,
   input wire logic rx_bit,
   input wire logic rx_start,
   input wire logic trim_edge,
   output logic timer_b_underflow,
   output logic timer_c_underflow,
   output logic timer_b_running,
   output logic timer_c_running,
   output logic irq
);
   logic [7:0] b_rel_hi_reg, b_rel_lo_reg, c_rel_hi_reg, c_rel_lo_reg;
   logic [7:0] b_ctl_reg, c_ctl_reg;
   logic [1:0] status_reg, mask_reg;
   logic [15:0] b_cnt_reg, c_cnt_reg;
   logic b_run_reg, c_run_reg, b_uf_reg, c_uf_reg;
   logic [2:0] rx_cnt_reg;
   logic trim_s1_reg, trim_s2_reg, trim_d_reg;
   logic [7:0] idx;
   logic acc, wr, rd_ok;
   logic b_tick, c_tick, b_start, c_start, c_trim, trim_rise, c_rx_stop;

   assign idx = paddr[9:2];
   assign acc = psel && penable;
   assign wr = acc && pwrite;
   assign pready = 1'b1;
   always_comb begin
      rd_ok = 1'b1;
      case (idx)
         TBRC_IDX_B_RELOAD_HIGH, TBRC_IDX_B_RELOAD_LOW, TBRC_IDX_B_COUNT_HIGH,
         TBRC_IDX_B_COUNT_LOW, TBRC_IDX_C_CONTROL, TBRC_IDX_C_RELOAD_HIGH,
         TBRC_IDX_C_RELOAD_LOW, TBRC_IDX_B_CONTROL, TBRC_IDX_STATUS, TBRC_IDX_MASK,
         TBRC_IDX_C_COUNT_HIGH, TBRC_IDX_C_COUNT_LOW: rd_ok = 1'b1;
         default: rd_ok = 1'b0;
      endcase
   end
   assign pslverr = acc && (!rd_ok || (paddr[1:0] != 2'h0));

   // reload and control storage; reload writes only land in these bytes
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         b_rel_hi_reg <= TBRC_RESET_BYTE;
         b_rel_lo_reg <= TBRC_RESET_BYTE;
         c_rel_hi_reg <= TBRC_RESET_BYTE;
         c_rel_lo_reg <= TBRC_RESET_BYTE;
         b_ctl_reg <= TBRC_RESET_BYTE;
         c_ctl_reg <= TBRC_RESET_BYTE;
         mask_reg <= 2'h0;
      end else if (wr && !pslverr) begin
         case (idx)
            TBRC_IDX_B_RELOAD_HIGH: b_rel_hi_reg <= pwdata[7:0];
            TBRC_IDX_B_RELOAD_LOW: b_rel_lo_reg <= pwdata[7:0];
            TBRC_IDX_C_RELOAD_HIGH: c_rel_hi_reg <= pwdata[7:0];
            TBRC_IDX_C_RELOAD_LOW: c_rel_lo_reg <= pwdata[7:0];
            TBRC_IDX_C_CONTROL: c_ctl_reg <= pwdata[7:0] & TBRC_CONTROL_MASK;
            TBRC_IDX_B_CONTROL: b_ctl_reg <= pwdata[7:0] & TBRC_CONTROL_MASK;
            TBRC_IDX_MASK: mask_reg <= pwdata[1:0];
            default: mask_reg <= mask_reg;
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         case (paddr[9:2])
            TBRC_IDX_B_RELOAD_HIGH: prdata <= {24'h00_0000, b_rel_hi_reg};
            TBRC_IDX_B_RELOAD_LOW: prdata <= {24'h00_0000, b_rel_lo_reg};
            TBRC_IDX_B_COUNT_HIGH: prdata <= {24'h00_0000, b_cnt_reg[15:8]};
            TBRC_IDX_B_COUNT_LOW: prdata <= {24'h00_0000, b_cnt_reg[7:0]};
            TBRC_IDX_C_CONTROL: prdata <= {24'h00_0000, c_ctl_reg};
            TBRC_IDX_C_RELOAD_HIGH: prdata <= {24'h00_0000, c_rel_hi_reg};
            TBRC_IDX_C_RELOAD_LOW: prdata <= {24'h00_0000, c_rel_lo_reg};
            TBRC_IDX_B_CONTROL: prdata <= {24'h00_0000, b_ctl_reg};
            TBRC_IDX_STATUS: prdata <= {30'h0000_0000, status_reg};
            TBRC_IDX_MASK: prdata <= {30'h0000_0000, mask_reg};
            TBRC_IDX_C_COUNT_HIGH: prdata <= {24'h00_0000, c_cnt_reg[15:8]};
            TBRC_IDX_C_COUNT_LOW: prdata <= {24'h00_0000, c_cnt_reg[7:0]};
            default: prdata <= 32'h0000_0000;
         endcase
      end
   end

   // trim edge arrives from the oscillator domain
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         trim_s1_reg <= 1'b0;
         trim_s2_reg <= 1'b0;
         trim_d_reg <= 1'b0;
      end else begin
         trim_s1_reg <= trim_edge;
         trim_s2_reg <= trim_s1_reg;
         trim_d_reg <= trim_s2_reg;
      end
   end
   assign trim_rise = trim_s2_reg && !trim_d_reg;

   function automatic logic tbrc_sel(input logic [1:0] s, input logic f, input logic sl,
                                     input logic ua, input logic uo);
      case (s)
         TBRC_CLK_FAST: tbrc_sel = f;
         TBRC_CLK_SLOW: tbrc_sel = sl;
         TBRC_CLK_UF_A: tbrc_sel = ua;
         default: tbrc_sel = uo;
      endcase
   endfunction

   // timer c's "other" is timer b; timer b's "other" is timer c
   assign b_tick = tbrc_sel(b_ctl_reg[TBRC_CLK_HI:TBRC_CLK_LO], tick_fast, tick_slow,
                            timer_a_underflow, c_uf_reg);
   assign c_tick = tbrc_sel(c_ctl_reg[TBRC_CLK_HI:TBRC_CLK_LO], tick_fast, tick_slow,
                            timer_a_underflow, b_uf_reg);

   assign b_start = (b_ctl_reg[TBRC_START_HI:TBRC_START_LO] == TBRC_START_EOT) && end_of_tx;
   assign c_trim = c_ctl_reg[TBRC_START_HI];
   assign c_start = ((c_ctl_reg[TBRC_START_HI:TBRC_START_LO] == TBRC_START_EOT) && end_of_tx)
                    || (c_trim && trim_rise && !c_run_reg);

   // timer b
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         b_cnt_reg <= TBRC_RESET_COUNT;
         b_run_reg <= 1'b0;
         b_uf_reg <= 1'b0;
      end else begin
         b_uf_reg <= 1'b0;
         if (b_start) begin
            b_cnt_reg <= {b_rel_hi_reg, b_rel_lo_reg};
            b_run_reg <= 1'b1;
         end else if (b_run_reg && b_tick) begin
            if (b_cnt_reg == TBRC_RESET_COUNT) begin
               b_uf_reg <= 1'b1;
               if (b_ctl_reg[TBRC_AUTO_BIT]) begin
                  b_cnt_reg <= {b_rel_hi_reg, b_rel_lo_reg};
               end else begin
                  b_run_reg <= 1'b0;
               end
            end else begin
               b_cnt_reg <= b_cnt_reg - 16'h0001;
            end
         end
      end
   end

   // receive bit counter for the early stop
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         rx_cnt_reg <= 3'h0;
      end else if (rx_start) begin
         rx_cnt_reg <= 3'h0;
      end else if (rx_bit && rx_cnt_reg != TBRC_RX_STOP_BITS) begin
         rx_cnt_reg <= rx_cnt_reg + 3'h1;
      end
   end
   assign c_rx_stop = c_ctl_reg[TBRC_STOP_RX_BIT] && !c_trim && rx_bit
                      && (rx_cnt_reg == TBRC_RX_STOP_BITS - 3'h1);

   // timer c; a trimming edge while running stops it
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         c_cnt_reg <= TBRC_RESET_COUNT;
         c_run_reg <= 1'b0;
         c_uf_reg <= 1'b0;
      end else begin
         c_uf_reg <= 1'b0;
         if (c_start) begin
            c_cnt_reg <= {c_rel_hi_reg, c_rel_lo_reg};
            c_run_reg <= 1'b1;
         end else if (c_rx_stop || (c_trim && trim_rise && c_run_reg)) begin
            c_run_reg <= 1'b0;
         end else if (c_run_reg && c_tick) begin
            if (c_cnt_reg == TBRC_RESET_COUNT) begin
               // trimming without underflow never reports; auto-restart still reloads
               if (c_ctl_reg[TBRC_START_HI:TBRC_START_LO] != TBRC_START_TRIM) begin
                  c_uf_reg <= 1'b1;
               end
               if (c_ctl_reg[TBRC_AUTO_BIT]) begin
                  c_cnt_reg <= {c_rel_hi_reg, c_rel_lo_reg};
               end else begin
                  c_run_reg <= 1'b0;
               end
            end else begin
               c_cnt_reg <= c_cnt_reg - 16'h0001;
            end
         end
      end
   end

   // sticky flags: a set in the clearing cycle wins
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         status_reg <= 2'h0;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if ((i == TBRC_IRQ_B) ? b_uf_reg : c_uf_reg) begin
               status_reg[i] <= 1'b1;
            end else if (wr && idx == TBRC_IDX_STATUS && pwdata[i]) begin
               status_reg[i] <= 1'b0;
            end
         end
      end
   end

   assign irq = |(status_reg & mask_reg);
   assign timer_b_underflow = b_uf_reg;
   assign timer_c_underflow = c_uf_reg;
   assign timer_b_running = b_run_reg;
   assign timer_c_running = c_run_reg;

   AST_B_LOAD: assert property (@(posedge core_clk) disable iff (!rst_b)
      b_start |=> b_cnt_reg == $past({b_rel_hi_reg, b_rel_lo_reg}))
      else $error("timer b did not load reload value");
   AST_B_RELOAD_HOLD: assert property (@(posedge core_clk) disable iff (!rst_b)
      (wr && idx == TBRC_IDX_B_RELOAD_LOW && b_run_reg && !b_start && !b_tick)
      |=> b_cnt_reg == $past(b_cnt_reg))
      else $error("reload write disturbed timer b");
   AST_C_LOAD: assert property (@(posedge core_clk) disable iff (!rst_b)
      c_start |=> c_cnt_reg == $past({c_rel_hi_reg, c_rel_lo_reg}) && c_run_reg)
      else $error("timer c did not load reload value");
   AST_B_READ: assert property (@(posedge core_clk) disable iff (!rst_b)
      (psel && !penable && !pwrite && idx == TBRC_IDX_B_COUNT_LOW)
      |=> prdata[7:0] == $past(b_cnt_reg[7:0]))
      else $error("timer b low count read wrong");
   AST_C_RX_STOP: assert property (@(posedge core_clk) disable iff (!rst_b)
      (c_rx_stop && !c_start) |=> !c_run_reg)
      else $error("timer c did not stop after four bits");
   AST_C_TRIM_IGNORE: assert property (@(posedge core_clk) disable iff (!rst_b)
      c_trim |-> !c_rx_stop)
      else $error("stop on receive active in trimming");
   AST_C_ONE_SHOT: assert property (@(posedge core_clk) disable iff (!rst_b)
      (c_run_reg && c_tick && c_cnt_reg == 16'h0000 && !c_ctl_reg[TBRC_AUTO_BIT]
       && !c_start && !c_rx_stop && !(c_trim && trim_rise)) |=> !c_run_reg)
      else $error("timer c did not stop at zero");
   AST_C_FLAG: assert property (@(posedge core_clk) disable iff (!rst_b)
      c_uf_reg |=> status_reg[TBRC_IRQ_C])
      else $error("timer c flag not set");
   AST_B_RESTART: assert property (@(posedge core_clk) disable iff (!rst_b)
      (b_run_reg && b_tick && b_cnt_reg == 16'h0000 && b_ctl_reg[TBRC_AUTO_BIT] && !b_start)
      |=> b_run_reg && b_uf_reg)
      else $error("timer b did not restart");
   AST_B_DEC: assert property (@(posedge core_clk) disable iff (!rst_b)
      (b_run_reg && b_tick && !b_start && b_cnt_reg != 16'h0000)
      |=> b_cnt_reg == $past(b_cnt_reg) - 16'h0001)
      else $error("timer b did not decrement");
   AST_B_FLAG: assert property (@(posedge core_clk) disable iff (!rst_b)
      b_uf_reg |=> status_reg[TBRC_IRQ_B])
      else $error("timer b flag not set");
   AST_B_ONE_SHOT: assert property (@(posedge core_clk) disable iff (!rst_b)
      (b_run_reg && b_tick && b_cnt_reg == 16'h0000 && !b_ctl_reg[TBRC_AUTO_BIT] && !b_start)
      |=> !b_run_reg && b_uf_reg)
      else $error("timer b did not stop at zero");
   AST_C_DEC: assert property (@(posedge core_clk) disable iff (!rst_b)
      (c_run_reg && c_tick && !c_start && !c_rx_stop && !(c_trim && trim_rise)
       && c_cnt_reg != 16'h0000) |=> c_cnt_reg == $past(c_cnt_reg) - 16'h0001)
      else $error("timer c did not decrement");
   AST_C_TRIM_STOP: assert property (@(posedge core_clk) disable iff (!rst_b)
      (c_trim && trim_rise && c_run_reg && !c_start) |=> !c_run_reg)
      else $error("timer c not stopped by trimming edge");
   AST_C_TRIM_NO_UF: assert property (@(posedge core_clk) disable iff (!rst_b)
      (c_ctl_reg[TBRC_START_HI:TBRC_START_LO] == TBRC_START_TRIM) |=> !c_uf_reg)
      else $error("timer c underflow in trimming without underflow");
   AST_CTL_RSVD: assert property (@(posedge core_clk) disable iff (!rst_b)
      (c_ctl_reg & ~TBRC_CONTROL_MASK) == 8'h00)
      else $error("reserved control bits set");
   COV_C_TRIM: cover property (@(posedge core_clk) disable iff (!rst_b) c_trim && trim_rise);
   COV_B_UF: cover property (@(posedge core_clk) disable iff (!rst_b) b_uf_reg);
   COV_C_RX: cover property (@(posedge core_clk) disable iff (!rst_b) c_rx_stop && c_run_reg);
   COV_IRQ: cover property (@(posedge core_clk) disable iff (!rst_b) irq);
endmodule

// file: dv/tb.sv
// Purpose: self-checking bench for the timer b / timer c reload and control block
// Assumes: zero-wait apb slave, event inputs are one-cycle pulses on core_clk
// Notes: read results are queued by the driver and compared by a monitor
module tb;
   import tbrc_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk, rst_b, psel, penable, pwrite, trim_edge;
   logic [31:0] paddr, pwdata, prdata;
   logic pready, pslverr, b_uf, c_uf, b_run, c_run, irq;
   logic [5:0] ev;
   logic [7:0] exp_q[$];
   logic [15:0] rnd;
   int fail_count, total_checks, cyc, b_uf_n, c_uf_n;
   tbrc_top u_dut (.core_clk(core_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .tick_fast(ev[0]), .tick_slow(ev[1]), .timer_a_underflow(ev[2]),
      .end_of_tx(ev[3]), .rx_bit(ev[4]), .rx_start(ev[5]), .trim_edge(trim_edge),
      .timer_b_underflow(b_uf), .timer_c_underflow(c_uf), .timer_b_running(b_run),
      .timer_c_running(c_run), .irq(irq));
   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end
   function automatic logic [15:0] lfsr(logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   function automatic logic [31:0] ad(logic [7:0] i);
      return {22'h0, i, 2'b00};
   endfunction
   task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic close_out();
      if (fail_count == 0 && total_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // one transfer; a read notes its expected byte for the monitor
   task automatic apb(logic w, logic [31:0] a, logic [7:0] d, logic err);
      @(posedge core_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h00_0000, d};
      if (!w) exp_q.push_back(err ? 8'h00 : d);
      @(posedge core_clk);
      penable <= 1'b1;
      do begin
         @(posedge core_clk);
      end while (pready !== 1'b1);
      check("pslverr", pslverr, err);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic pulse(int i);
      @(posedge core_clk);
      ev[i] <= 1'b1;
      @(posedge core_clk);
      ev[i] <= 1'b0;
   endtask
   task automatic idle(int n);
      repeat (n) @(posedge core_clk);
   endtask
   always @(posedge core_clk) begin
      if (psel && penable && !pwrite && pready) begin
         check("read data", prdata, {24'h00_0000, exp_q.pop_front()});
      end
      if (b_uf === 1'b1) b_uf_n++;
      if (c_uf === 1'b1) c_uf_n++;
      cyc++;
      if (cyc == 20000) begin
         fail_count++;
         close_out();
      end
   end
   initial begin
      logic [7:0] regs[5];
      logic [1:0] src[4];
      int n;
      regs = '{TBRC_IDX_B_RELOAD_HIGH, TBRC_IDX_B_RELOAD_LOW, TBRC_IDX_C_RELOAD_HIGH,
               TBRC_IDX_C_RELOAD_LOW, TBRC_IDX_C_CONTROL};
      src = '{2'h0, 2'h1, 2'h2, 2'h0};
      rst_b = 1'b0;
      {psel, penable, pwrite, trim_edge} = 4'h0;
      paddr = 32'h0000_0000;
      pwdata = 32'h0000_0000;
      ev = 6'h00;
      rnd = 16'h0002;
      idle(3);
      rst_b <= 1'b1;
      for (int i = 8'h1A; i <= 8'h20; i++) apb(1'b0, ad(i), 8'h00, 1'b0);
      for (int i = 0; i < 5; i++) begin
         rnd = lfsr(rnd);
         apb(1'b1, ad(regs[i]), rnd[7:0], 1'b0);
         apb(1'b0, ad(regs[i]), (i == 4) ? rnd[7:0] & TBRC_CONTROL_MASK : rnd[7:0], 1'b0);
      end
      apb(1'b1, ad(TBRC_IDX_C_CONTROL), 8'h00, 1'b0);
      apb(1'b1, ad(TBRC_IDX_B_COUNT_LOW), 8'hFF, 1'b0);
      apb(1'b0, ad(TBRC_IDX_B_COUNT_LOW), 8'h00, 1'b0);
      apb(1'b0, 32'h0000_0100, 8'h00, 1'b1);
      apb(1'b1, 32'h0000_0069, 8'h55, 1'b1);
      // timer b one-shot, reload rewritten mid-count
      apb(1'b1, ad(TBRC_IDX_B_RELOAD_HIGH), 8'h00, 1'b0);
      apb(1'b1, ad(TBRC_IDX_B_RELOAD_LOW), 8'h03, 1'b0);
      apb(1'b1, ad(TBRC_IDX_B_CONTROL), 8'h10, 1'b0);
      apb(1'b1, ad(TBRC_IDX_MASK), 8'h03, 1'b0);
      pulse(3);
      idle(2);
      check("b running", b_run, 1'b1);
      apb(1'b1, ad(TBRC_IDX_B_RELOAD_LOW), 8'h09, 1'b0);
      apb(1'b0, ad(TBRC_IDX_B_COUNT_HIGH), 8'h00, 1'b0);
      apb(1'b0, ad(TBRC_IDX_B_COUNT_LOW), 8'h03, 1'b0);
      repeat (3) pulse(0);
      idle(2);
      apb(1'b0, ad(TBRC_IDX_B_COUNT_LOW), 8'h00, 1'b0);
      check("b uf early", b_uf_n, 0);
      pulse(0);
      idle(3);
      check("b uf", b_uf_n, 1);
      check("b stopped", b_run, 1'b0);
      apb(1'b0, ad(TBRC_IDX_STATUS), 8'h01, 1'b0);
      check("irq on", irq, 1'b1);
      apb(1'b1, ad(TBRC_IDX_MASK), 8'h00, 1'b0);
      idle(1);
      check("irq masked", irq, 1'b0);
      apb(1'b1, ad(TBRC_IDX_MASK), 8'h03, 1'b0);
      apb(1'b1, ad(TBRC_IDX_STATUS), 8'h01, 1'b0);
      idle(1);
      check("irq cleared", irq, 1'b0);
      pulse(3);
      idle(2);
      apb(1'b0, ad(TBRC_IDX_B_COUNT_LOW), 8'h09, 1'b0);
      // timer c clock sources, reload zero so one tick underflows
      apb(1'b1, ad(TBRC_IDX_C_RELOAD_HIGH), 8'h00, 1'b0);
      apb(1'b1, ad(TBRC_IDX_C_RELOAD_LOW), 8'h00, 1'b0);
      apb(1'b1, ad(TBRC_IDX_B_RELOAD_LOW), 8'h00, 1'b0);
      for (int s = 0; s < 4; s++) begin
         apb(1'b1, ad(TBRC_IDX_C_CONTROL), 8'h10 | s, 1'b0);
         pulse(3);
         n = c_uf_n;
         if (s == 1 || s == 2) pulse(0);
         idle(3);
         check("c wrong clock", c_uf_n, n);
         pulse(src[s]);
         idle(4);
         check("c uf", c_uf_n, n + 1);
         check("c stopped", c_run, 1'b0);
      end
      apb(1'b0, ad(TBRC_IDX_STATUS), 8'h03, 1'b0);
      apb(1'b1, ad(TBRC_IDX_STATUS), 8'h03, 1'b0);
      // timer c auto restart
      apb(1'b1, ad(TBRC_IDX_C_RELOAD_LOW), 8'h01, 1'b0);
      apb(1'b1, ad(TBRC_IDX_C_CONTROL), 8'h19, 1'b0);
      pulse(3);
      n = c_uf_n;
      repeat (4) pulse(1);
      idle(2);
      check("c auto uf", c_uf_n, n + 2);
      check("c auto running", c_run, 1'b1);
      apb(1'b0, ad(TBRC_IDX_C_COUNT_LOW), 8'h01, 1'b0);
      apb(1'b0, ad(TBRC_IDX_STATUS), 8'h02, 1'b0);
      // stop on receive after the fourth bit
      apb(1'b1, ad(TBRC_IDX_C_CONTROL), 8'h99, 1'b0);
      pulse(5);
      repeat (3) pulse(4);
      idle(1);
      check("c before 4 bits", c_run, 1'b1);
      pulse(4);
      idle(2);
      check("c stop rx", c_run, 1'b0);
      // trimming start and stop on rising edges, receive stop ignored
      apb(1'b1, ad(TBRC_IDX_C_CONTROL), 8'hA1, 1'b0);
      @(posedge core_clk) trim_edge <= 1'b1;
      idle(5);
      check("c trim start", c_run, 1'b1);
      pulse(5);
      repeat (4) pulse(4);
      idle(2);
      check("c trim no rx stop", c_run, 1'b1);
      @(posedge core_clk) trim_edge <= 1'b0;
      idle(4);
      trim_edge <= 1'b1;
      idle(5);
      check("c trim stop", c_run, 1'b0);
      apb(1'b1, ad(TBRC_IDX_C_CONTROL), 8'h01, 1'b0);
      pulse(3);
      idle(2);
      check("c no auto start", c_run, 1'b0);
      // timer b auto restart: reload 2 gives an underflow every third tick
      apb(1'b1, ad(TBRC_IDX_B_RELOAD_LOW), 8'h02, 1'b0);
      apb(1'b1, ad(TBRC_IDX_B_CONTROL), 8'h18, 1'b0);
      pulse(3);
      n = b_uf_n;
      repeat (6) pulse(0);
      idle(2);
      check("b auto uf", b_uf_n, n + 2);
      check("b auto running", b_run, 1'b1);
      idle(2);
      close_out();
   end
endmodule
